/* File: common/ccs_map.vh */
// chain layout, field positions and timing counts for the configuration scan register
`ifndef CCS_MAP_VH
`define CCS_MAP_VH
`define CCS_CHAIN_LEN 53
`define CCS_MASK_LO 0
`define CCS_CAL_LO 8
`define CCS_THR_LO 11
`define CCS_CTHR_LO 19
`define CCS_HYST_LO 22
`define CCS_GATE_LO 26
`define CCS_RUND_LO 30
`define CCS_DEAD_LO 33
`define CCS_MODE_LO 36
`define CCS_OMODE_BIT 52
`define CCS_MODE_ACTIVE 2'h0
`define CCS_MODE_FORCE_LO 2'h2
`define CCS_MODE_FORCE_HI 2'h3
`define CCS_SYNC_STAGES 2
`endif

/* File: design/ccs_sync.v */
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module ccs_sync #(
  parameter W = 4
) (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // pin levels in, synchronised levels out
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_r;
  // first stage read only by the second
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* File: design/ccs_mode_dec.v */
// per-channel output mode decoder, registered
`timescale 1ns/1ps
`default_nettype none
`include "ccs_map.vh"
module ccs_mode_dec (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // packed 2-bit mode codes and channel masks
  input wire [15:0] mode_i,
  input wire [7:0] mask_i,
  // per-channel decoded controls
  output reg [7:0] active_o,
  output reg [7:0] force_lo_o,
  output reg [7:0] force_hi_o
);
  genvar g;
  // one decoder per channel
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_ch
      wire [1:0] code;
      assign code = mode_i[2*g+1:2*g];
      always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          active_o[g] <= 1'b0;
          force_lo_o[g] <= 1'b1;
          force_hi_o[g] <= 1'b0;
        end else begin
          active_o[g] <= (code == `CCS_MODE_ACTIVE) & ~mask_i[g];
          force_lo_o[g] <= (code == `CCS_MODE_FORCE_LO) | (code == 2'h1) | mask_i[g];
          force_hi_o[g] <= (code == `CCS_MODE_FORCE_HI) & ~mask_i[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: design/ccs_chain.v */
// 53-bit configuration scan chain with update latch and field decode
//
// Summary of operation
// - eleven settings held in one 53-bit chain; mode counted as two 8-bit registers
// - chain bits 0..7 are channel mask, bit 0 for channel 0
// - chain bits 8..10 select calibration capacitor, bit 10 least significant
// - chain bits 11..18 main comparator threshold, bit 18 least significant
// - chain bits 19..21 converter comparator threshold, bit 21 least significant
// - chain bits 22..25 hysteresis code, bit 25 least significant
// - chain bits 26..29 integration gate code, bit 29 least significant
// - chain bits 30..32 rundown current code, bit 32 least significant
// - chain bits 36..51 two mode bits per channel, channel 0 first
// - rundown current falls as code rises; inverted code drives current
`timescale 1ns/1ps
`default_nettype none
`include "ccs_map.vh"
module ccs_chain (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // test access pins (asynchronous to clk_i)
  input wire tck_i,
  input wire tdi_i,
  input wire shift_en_i,
  input wire capture_en_i,
  input wire update_en_i,
  output reg tdo_o,
  // decoded settings
  output reg [7:0] channel_mask_o,
  output reg [2:0] calibration_capacitor_select_o,
  output reg [7:0] main_threshold_code_o,
  output reg [2:0] converter_threshold_code_o,
  output reg [3:0] hysteresis_code_o,
  output reg [3:0] integration_gate_code_o,
  output reg [2:0] rundown_current_code_o,
  output reg [2:0] rundown_current_drive_o,
  output reg [2:0] dead_time_code_o,
  output reg [7:0] channel_mode_low_channels_o,
  output reg [7:0] channel_mode_high_channels_o,
  output reg output_mode_select_o,
  // per-channel output control
  output wire [7:0] channel_active_o,
  output wire [7:0] channel_force_lo_o,
  output wire [7:0] channel_force_hi_o
);
  // ****************************************
  // pin synchronisation and edge detection
  // ****************************************
  wire [4:0] pins_s;
  reg tck_d_r;
  wire tck_rise;
  wire tck_fall;
  ccs_sync #(.W(5)) u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i({tck_i, tdi_i, shift_en_i, capture_en_i, update_en_i}),
    .q_o(pins_s)
  );
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= pins_s[4];
    end
  end
  assign tck_rise = pins_s[4] & ~tck_d_r;
  assign tck_fall = ~pins_s[4] & tck_d_r;

  // ****************************************
  // shift and update stages
  // ****************************************
  // chain index 0 is the first bit shifted out; data enters at the top
  reg [`CCS_CHAIN_LEN-1:0] shift_r;
  reg [`CCS_CHAIN_LEN-1:0] hold_r;
  // shift on rising test clock, capture loads held values
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_r <= {`CCS_CHAIN_LEN{1'b0}};
    end else if (tck_rise && pins_s[1]) begin
      shift_r <= hold_r;
    end else if (tck_rise && pins_s[2]) begin
      shift_r <= {pins_s[3], shift_r[`CCS_CHAIN_LEN-1:1]};
    end
  end
  // update copies chain into the holding stage on a rising test clock unless shift is enabled
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_r <= {`CCS_CHAIN_LEN{1'b0}};
    end else if (tck_rise && pins_s[0] && !pins_s[2]) begin
      hold_r <= shift_r;
    end
  end
  // serial out changes on falling test clock
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tdo_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= shift_r[0];
    end
  end

  // ****************************************
  // field decode; chain index of lsb is the highest of each field except the channel mask, whose lsb is bit 0
  // ****************************************
  function [7:0] rev8;
    input [7:0] v;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        rev8[k] = v[7-k];
      end
    end
  endfunction
  wire [15:0] mode_packed;
  genvar g;
  // channel n mode bits at 36+2n (msb) and 37+2n (lsb)
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_mode
      assign mode_packed[2*g+1] = hold_r[`CCS_MODE_LO+2*g];
      assign mode_packed[2*g] = hold_r[`CCS_MODE_LO+2*g+1];
    end
  endgenerate
  // registered fields
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      channel_mask_o <= 8'h00;
      calibration_capacitor_select_o <= 3'h0;
      main_threshold_code_o <= 8'h00;
      converter_threshold_code_o <= 3'h0;
      hysteresis_code_o <= 4'h0;
      integration_gate_code_o <= 4'h0;
      rundown_current_code_o <= 3'h0;
      rundown_current_drive_o <= 3'h7;
      dead_time_code_o <= 3'h0;
      channel_mode_low_channels_o <= 8'h00;
      channel_mode_high_channels_o <= 8'h00;
      output_mode_select_o <= 1'b0;
    end else begin
      channel_mask_o <= hold_r[`CCS_MASK_LO+7:`CCS_MASK_LO];
      calibration_capacitor_select_o <= {hold_r[8], hold_r[9], hold_r[10]};
      main_threshold_code_o <= rev8(hold_r[`CCS_THR_LO+7:`CCS_THR_LO]);
      converter_threshold_code_o <= {hold_r[19], hold_r[20], hold_r[21]};
      hysteresis_code_o <= {hold_r[22], hold_r[23], hold_r[24], hold_r[25]};
      integration_gate_code_o <= {hold_r[26], hold_r[27], hold_r[28], hold_r[29]};
      rundown_current_code_o <= {hold_r[30], hold_r[31], hold_r[32]};
      rundown_current_drive_o <= ~{hold_r[30], hold_r[31], hold_r[32]};
      dead_time_code_o <= {hold_r[33], hold_r[34], hold_r[35]};
      channel_mode_low_channels_o <= mode_packed[7:0];
      channel_mode_high_channels_o <= mode_packed[15:8];
      output_mode_select_o <= hold_r[`CCS_OMODE_BIT];
    end
  end

  // per-channel decode
  ccs_mode_dec u_dec (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .mode_i({channel_mode_high_channels_o, channel_mode_low_channels_o}),
    .mask_i(channel_mask_o),
    .active_o(channel_active_o),
    .force_lo_o(channel_force_lo_o),
    .force_hi_o(channel_force_hi_o)
  );
endmodule
`default_nettype wire

/* File: testbench/ccs_chain_chk.sv */
// assertion checker for the configuration scan register
`timescale 1ns/1ps
`default_nettype none
module ccs_chain_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // test access pins
  input wire logic tck_i,
  input wire logic shift_en_i,
  input wire logic update_en_i,
  input wire logic tdo_o,
  // held settings and decodes
  input wire logic [7:0] channel_mask_o,
  input wire logic [7:0] main_threshold_code_o,
  input wire logic [7:0] channel_mode_low_channels_o,
  input wire logic [7:0] channel_mode_high_channels_o,
  input wire logic [7:0] channel_active_o,
  input wire logic [7:0] channel_force_lo_o,
  input wire logic [7:0] channel_force_hi_o,
  input wire logic [2:0] rundown_current_code_o,
  input wire logic [2:0] rundown_current_drive_o
);
  logic [15:0] md;
  logic [7:0] ea;
  // active channels expected from mask and mode
  assign md = {channel_mode_high_channels_o, channel_mode_low_channels_o};
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      ea[n] = !channel_mask_o[n] && md[2*n+:2] == 2'h0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  chk_drive_inv: assert property (rundown_current_drive_o == ~rundown_current_code_o)
    else $error("drive");
  chk_dec_act: assert property ($past(arst_n_i) |-> channel_active_o == $past(ea))
    else $error("active");
  chk_mask_low: assert property ($past(arst_n_i) |->
    (channel_force_lo_o & $past(channel_mask_o)) == $past(channel_mask_o)) else $error("mask");
  chk_act_excl: assert property (
    (channel_active_o & (channel_force_lo_o | channel_force_hi_o)) == 8'h0) else $error("excl");
  chk_dec_full: assert property (
    (channel_active_o | channel_force_lo_o | channel_force_hi_o) == 8'hff) else $error("none");
  chk_thr_idle: assert property (!update_en_i [*6] |=> $stable(main_threshold_code_o))
    else $error("thr");
  chk_upd_refused: assert property (shift_en_i [*6] |=> $stable(channel_mask_o))
    else $error("refuse");
  chk_tdo_steady: assert property (tck_i [*6] |=> $stable(tdo_o))
    else $error("tdo");
endmodule
`default_nettype wire

/* File: testbench/ccs_jtag_model.sv */
// scan controller model driving the test access pins
`timescale 1ns/1ps
`default_nettype none
module ccs_jtag_model (
  // clock and chain output
  input wire logic clk_i,
  input wire logic tdo_i,
  // test access pins
  output logic tck_o,
  output logic tdi_o,
  output logic shift_en_o,
  output logic capture_en_o,
  output logic update_en_o
);
  initial {tck_o, tdi_o, shift_en_o, capture_en_o, update_en_o} = 5'h0;
  // one 160 ns tck period (10 clk low, 10 clk high), tdo taken before the rise
  task automatic tick(input logic s, c, u, d, output logic q);
    @(posedge clk_i);
    {shift_en_o, capture_en_o, update_en_o, tdi_o} <= {s, c, u, d};
    repeat (9) @(posedge clk_i);
    q = tdo_i;
    tck_o <= 1'h1;
    repeat (10) @(posedge clk_i);
    tck_o <= 1'h0;
  endtask
  // capture, shift bit 0 first, update; k keeps shift high
  task automatic xfer(input logic [52:0] v, input logic k, output logic [52:0] r);
    logic q;
    tick(1'h0, 1'h1, 1'h0, 1'h0, q);
    for (int i = 0; i < 53; i++) tick(1'h1, 1'h0, 1'h0, v[i], r[i]);
    tick(k, 1'h0, 1'h1, ~v[52], q);
    @(posedge clk_i);
    {shift_en_o, update_en_o, tdi_o} <= {2'h0, v[52]};
    repeat (8) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* File: testbench/ccs_chain_tb.sv */
// self-checking testbench for the configuration scan register
`timescale 1ns/1ps
`default_nettype none
module ccs_chain_tb;
  localparam logic [52:0] V1 = 53'h1d8d8e96c3a10;
  logic clk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic tck_i, tdi_i, shift_en_i, capture_en_i, update_en_i, tdo_o, output_mode_select_o;
  logic [7:0] channel_mask_o, main_threshold_code_o, channel_mode_low_channels_o;
  logic [7:0] channel_mode_high_channels_o, channel_active_o, channel_force_lo_o;
  logic [7:0] channel_force_hi_o;
  logic [3:0] hysteresis_code_o, integration_gate_code_o;
  logic [2:0] calibration_capacitor_select_o, converter_threshold_code_o, dead_time_code_o;
  logic [2:0] rundown_current_code_o, rundown_current_drive_o;
  int bad_count = 0;
  int tests_run = 0;
  // clock, design and scan controller
  initial forever #4 clk_i = ~clk_i;
  ccs_chain dut_u (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .tck_i(tck_i),
    .tdi_i(tdi_i),
    .shift_en_i(shift_en_i),
    .capture_en_i(capture_en_i),
    .update_en_i(update_en_i),
    .tdo_o(tdo_o),
    .channel_mask_o(channel_mask_o),
    .calibration_capacitor_select_o(calibration_capacitor_select_o),
    .main_threshold_code_o(main_threshold_code_o),
    .converter_threshold_code_o(converter_threshold_code_o),
    .hysteresis_code_o(hysteresis_code_o),
    .integration_gate_code_o(integration_gate_code_o),
    .rundown_current_code_o(rundown_current_code_o),
    .rundown_current_drive_o(rundown_current_drive_o),
    .dead_time_code_o(dead_time_code_o),
    .channel_mode_low_channels_o(channel_mode_low_channels_o),
    .channel_mode_high_channels_o(channel_mode_high_channels_o),
    .output_mode_select_o(output_mode_select_o),
    .channel_active_o(channel_active_o),
    .channel_force_lo_o(channel_force_lo_o),
    .channel_force_hi_o(channel_force_hi_o)
  );
  ccs_jtag_model m_u (.clk_i, .tdo_i(tdo_o), .tck_o(tck_i), .tdi_o(tdi_i),
    .shift_en_o(shift_en_i), .capture_en_o(capture_en_i), .update_en_o(update_en_i));
  task automatic check(input logic [52:0] s, e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic end_of_test;
    $display("%0d checks %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // load v, or refuse the update when k is set, then compare the fields
  task automatic t_xfer(input logic [52:0] v, p, input logic k);
    logic [52:0] r, e;
    logic [27:0] x, y;
    logic [15:0] m;
    logic [1:0] c;
    logic [2:0] d;
    m_u.xfer(v, k, r);
    e = k ? p : v;
    x = {<<{e[35:8]}};
    y = {calibration_capacitor_select_o, main_threshold_code_o, converter_threshold_code_o,
      hysteresis_code_o, integration_gate_code_o, rundown_current_code_o, dead_time_code_o};
    m = {channel_mode_high_channels_o, channel_mode_low_channels_o};
    check(r, p);
    check({channel_mask_o, output_mode_select_o}, {e[7:0], e[52]});
    check(y, x);
    check(rundown_current_drive_o ^ x[5:3], 53'h7);
    for (int n = 0; n < 8; n++) begin
      c = {e[36+2*n], e[37+2*n]};
      check(m[2*n+:2], c);
      // masked or 01/10 forced low, 00 active, 11 forced high: {active, high, low}
      d = e[n] ? 3'h1 : c == 2'h0 ? 3'h4 : c == 2'h3 ? 3'h2 : 3'h1;
      check({channel_active_o[n], channel_force_hi_o[n], channel_force_lo_o[n]}, d);
    end
  endtask
  // hold reset for n cycles, check the reset values, then release
  task automatic t_reset(input int n);
    arst_n_i <= 1'h0;
    repeat (n - 1) @(posedge clk_i);
    check({rundown_current_drive_o, channel_force_lo_o}, {3'h7, 8'hff});
    check({channel_mask_o, channel_active_o, channel_force_hi_o}, 24'h0);
    @(posedge clk_i);
    arst_n_i <= 1'h1;
  endtask
  // reset, load, reload, refused update, reset in mid-run, load from cleared state
  initial begin
    t_reset(20);
    t_xfer(V1, 53'h0, 1'h0);
    t_xfer(~V1, V1, 1'h0);
    t_xfer(V1, ~V1, 1'h1);
    t_reset(4);
    t_xfer(~V1, 53'h0, 1'h0);
    end_of_test;
  end
endmodule
bind ccs_chain ccs_chain_chk chk_u (
  .clk_i(clk_i),
  .arst_n_i(arst_n_i),
  .tck_i(tck_i),
  .shift_en_i(shift_en_i),
  .update_en_i(update_en_i),
  .tdo_o(tdo_o),
  .channel_mask_o(channel_mask_o),
  .main_threshold_code_o(main_threshold_code_o),
  .channel_mode_low_channels_o(channel_mode_low_channels_o),
  .channel_mode_high_channels_o(channel_mode_high_channels_o),
  .channel_active_o(channel_active_o),
  .channel_force_lo_o(channel_force_lo_o),
  .channel_force_hi_o(channel_force_hi_o),
  .rundown_current_code_o(rundown_current_code_o),
  .rundown_current_drive_o(rundown_current_drive_o)
);
`default_nettype wire
